// ===== rtl/port_ovr_pkg.sv
package port_ovr_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_PORT_A_INPUT_LEVELS = 4'h0;
   localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h1;
   localparam logic [3:0] IDX_PORT_A_OUTPUT_DATA = 4'h2;
   localparam logic [3:0] IDX_PORT_A_PULLUP_ENABLE = 4'h3;
   localparam logic [3:0] IDX_PORT_CONTROL = 4'h8;
   localparam int ADR_IDX_LSB = 2;
   localparam int ADR_IDX_MSB = 5;

   // reset values
   localparam logic [7:0] RST_PORT_A_DIRECTION = 8'h00;
   localparam logic [7:0] RST_PORT_A_OUTPUT_DATA = 8'h00;
   localparam logic [7:0] RST_PORT_A_PULLUP_ENABLE = 8'h00;
   localparam logic [7:0] RST_PORT_CONTROL = 8'h00;

   // port control layout; bit 3 reserved
   localparam logic [7:0] PORT_CONTROL_MASK = 8'hf7;
   localparam int BIT_GAP_SWITCH_PORT_A = 0;
   localparam int BIT_GAP_SWITCH_PORT_B = 1;
   localparam int BIT_GAP_SWITCH_PORT_C = 2;
   localparam int BIT_ANALOG8_INPUT_OFF = 4;
   localparam int BIT_ANALOG9_INPUT_OFF = 5;
   localparam int BIT_ANALOG10_INPUT_OFF = 6;
   localparam int BIT_ANALOG11_INPUT_OFF = 7;

   // pad widths and third-port pad positions
   localparam int PORT_A_WIDTH = 8;
   localparam int PORT_B_WIDTH = 4;
   localparam int PORT_C_WIDTH = 6;
   localparam int PAD_SELECT = 0;
   localparam int PAD_SERIAL_CLOCK = 1;
   localparam int PAD_CLOCK_OUT = 2;
   localparam int PAD_RESET = 3;
   localparam int PAD_SHARED_DATA = 4;
   localparam int PAD_CLOCK_IN = 5;

   // two-wire spike filter timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SPIKE_FILTER_NS = 50;
   localparam int SPIKE_FILTER_CYCLES_INT = (SPIKE_FILTER_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam logic [3:0] SPIKE_FILTER_CYCLES = SPIKE_FILTER_CYCLES_INT[3:0];
endpackage

// ===== rtl/pad_override_mux.sv
`timescale 1ns/1ps
// chooses between the port-register path and the alternate-function overrides for one pad
module pad_override_mux (
   input wire logic regPullup,
   input wire logic regDir,
   input wire logic regOut,
   input wire logic pullupOvrEn,
   input wire logic pullupOvrVal,
   input wire logic dirOvrEn,
   input wire logic dirOvrVal,
   input wire logic outvalOvrEn,
   input wire logic outvalOvrVal,
   input wire logic inbufOvrEn,
   input wire logic inbufOvrVal,
   output logic padPullup,
   output logic padDir,
   output logic padOut,
   output logic inbufOn
);
   logic basePullup;

   // register path pull-up only acts on an input pad
   assign basePullup = regPullup & ~regDir;

   // each override enable replaces the register-derived control, or the always-on default for the input buffer
   assign padPullup = pullupOvrEn ? pullupOvrVal : basePullup; // R17
   assign padDir = dirOvrEn ? dirOvrVal : regDir; // R17
   assign padOut = outvalOvrEn ? outvalOvrVal : regOut; // R17
   assign inbufOn = inbufOvrEn ? inbufOvrVal : 1'b1; // R17
endmodule

// ===== rtl/bbm_gap.sv
`timescale 1ns/1ps
// break-before-make: a direction bit turning to output first spends one cycle tri-stated
module bbm_gap #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic gapOn,
   input wire logic [WIDTH-1:0] dirIn,
   output logic [WIDTH-1:0] dirOut
);
   logic [WIDTH-1:0] dirPrev_reg;

   // remembers last cycle's direction to spot a fresh turn to output
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dirPrev_reg <= '0;
      end
      else
      begin
         dirPrev_reg <= dirIn;
      end
   end

   // hold a newly made output in tri-state for the first cycle
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         assign dirOut[i] = dirIn[i] & ~(gapOn & ~dirPrev_reg[i]); // R15
      end
   endgenerate
endmodule

// ===== rtl/port_override_and_port_a_regs.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// Operation
// R1: external clock frees clock-input pad completely
// R2: clock-input buffer override and held-on conditions
// R3: shared data pad direction/value from host, two-wire
// R4: shared data buffer on by source 16
// R5: reset function forces pull-up, input, buffer override
// R6: clock-out flag drives system clock out
// R7: host mode also overrides clock-out pad
// R8: clock-out buffer on by source 14, irq0
// R9: serial-clock pad overrides for two-wire or host
// R10: serial-clock input routing, buffer by source 13
// R11: select pad input in host, compare-A output
// R12: two-wire enables slew control and spike filter
// R13: clock-input pad feeds pin-change source 17
// R14: port control bit 3 reads zero
// R15: gap switching inserts one tri-state cycle
// R16: analog input-off bits gate second-port buffers
// R17: override enable selects override value per pad
// R18: first-port registers drive matching pads, synced input
module port_override_and_port_a_regs (
   input wire logic mclk,
   input wire logic rst_n,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // first port pads
   input wire logic [7:0] padAIn,
   output logic [7:0] padAOut,
   output logic [7:0] padADriveN,
   output logic [7:0] padAPullup,
   // third port pads
   input wire logic [5:0] padCIn,
   output logic [5:0] padCOut,
   output logic [5:0] padCDriveN,
   output logic [5:0] padCPullup,
   output logic [5:0] padCInbufOn,
   output logic [5:0] padCLevel,
   output logic slewLimitData,
   output logic slewLimitClock,
   // third port register path from its own registers
   input wire logic [5:0] portCPullupReg,
   input wire logic [5:0] portCDirReg,
   input wire logic [5:0] portCOutReg,
   // second port overrides and gap enable
   input wire logic [3:0] pinchgSrcB,
   output logic [3:0] padBInbufOvrEn,
   output logic [3:0] padBInbufOvrVal,
   output logic gapSwitchPortB,
   // device configuration and peripheral state
   input wire logic externalSysclkSel,
   input wire logic deepSleepActive,
   input wire logic resetPinFunctionFlag,
   input wire logic clockOutFuse,
   input wire logic pinchgGroup1On,
   input wire logic pinchgGroup2On,
   input wire logic pinchgSrc12,
   input wire logic pinchgSrc13,
   input wire logic pinchgSrc14,
   input wire logic pinchgSrc15,
   input wire logic pinchgSrc16,
   input wire logic pinchgSrc17,
   input wire logic serialPeriphOn,
   input wire logic serialPeriphHostMode,
   input wire logic twoWireOn,
   input wire logic twoWireDataDrive,
   input wire logic twoWireClockDrive,
   input wire logic spiHostTransmit,
   input wire logic spiTargetTransmit,
   input wire logic spiHostClockDrive,
   input wire logic extIrq0Used,
   input wire logic cmpAOutputDriveOn,
   input wire logic cmpAWaveform,
   // routed pad inputs
   output logic extClockPinIn,
   output logic pinchgIn12,
   output logic pinchgIn13,
   output logic pinchgIn14,
   output logic pinchgIn15,
   output logic pinchgIn16,
   output logic pinchgIn17,
   output logic spiTargetReceive,
   output logic spiHostReceive,
   output logic spiClockIn,
   output logic spiSelectIn,
   output logic extIrq0Source,
   output logic capture1Input,
   output logic timer1CountSource,
   output logic twoWireClockIn,
   output logic twoWireDataIn
);
   logic [7:0] portADir_reg;
   logic [7:0] portAOut_reg;
   logic [7:0] portAPullup_reg;
   logic [7:0] portControl_reg;
   logic [7:0] padASync1_reg;
   logic [7:0] padASync2_reg;
   logic [5:0] padCSync1_reg;
   logic [5:0] padCSync2_reg;
   logic ack_reg;
   logic [31:0] datOut_reg;
   logic [31:0] readData_next;
   logic [3:0] regIdx;
   logic reqValid;
   logic wrCommit;
   logic [7:0] wrByte;
   logic [7:0] padADirGap;
   logic [7:0] inbufA;
   logic [7:0] padALevel;
   logic [5:0] padCDirGap;
   logic [5:0] cPuoe;
   logic [5:0] cPuov;
   logic [5:0] cDdoe;
   logic [5:0] cDdov;
   logic [5:0] cPvoe;
   logic [5:0] cPvov;
   logic [5:0] cDieoe;
   logic [5:0] cDieov;
   logic [5:0] padCDir;
   logic [1:0] twRaw;
   logic twFilt_reg [2];
   logic [3:0] twCount_reg [2];
   logic spiHost;
   logic [3:0] analogOff;

   // bus decode: request seen once, committed at the edge where ack is high
   assign regIdx = adr_i[port_ovr_pkg::ADR_IDX_MSB:port_ovr_pkg::ADR_IDX_LSB];
   assign reqValid = cyc_i & stb_i;
   assign wrCommit = reqValid & we_i & ack_reg & sel_i[0];
   assign wrByte = dat_i[7:0];
   assign ack_o = ack_reg;
   assign dat_o = datOut_reg;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= reqValid & ~ack_reg;
      end
   end

   // read mux; unmapped indices read zero
   always_comb
   begin
      readData_next = 32'h0000_0000;
      case (regIdx)
         port_ovr_pkg::IDX_PORT_A_INPUT_LEVELS: readData_next[7:0] = padALevel; // R18
         port_ovr_pkg::IDX_PORT_A_DIRECTION: readData_next[7:0] = portADir_reg;
         port_ovr_pkg::IDX_PORT_A_OUTPUT_DATA: readData_next[7:0] = portAOut_reg;
         port_ovr_pkg::IDX_PORT_A_PULLUP_ENABLE: readData_next[7:0] = portAPullup_reg;
         port_ovr_pkg::IDX_PORT_CONTROL:
            readData_next[7:0] = portControl_reg & port_ovr_pkg::PORT_CONTROL_MASK; // R14
         default: readData_next = 32'h0000_0000;
      endcase
   end

   // read data captured with the request, held while ack is high
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         datOut_reg <= 32'h0000_0000;
      end
      else if (reqValid & ~ack_reg)
      begin
         datOut_reg <= readData_next;
      end
   end

   // first-port direction register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         portADir_reg <= port_ovr_pkg::RST_PORT_A_DIRECTION;
      end
      else if (wrCommit && regIdx == port_ovr_pkg::IDX_PORT_A_DIRECTION)
      begin
         portADir_reg <= wrByte;
      end
   end

   // first-port output data; writing ones to the input register toggles them
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         portAOut_reg <= port_ovr_pkg::RST_PORT_A_OUTPUT_DATA;
      end
      else if (wrCommit && regIdx == port_ovr_pkg::IDX_PORT_A_OUTPUT_DATA)
      begin
         portAOut_reg <= wrByte;
      end
      else if (wrCommit && regIdx == port_ovr_pkg::IDX_PORT_A_INPUT_LEVELS)
      begin
         portAOut_reg <= portAOut_reg ^ wrByte;
      end
   end

   // first-port pull-up enables
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         portAPullup_reg <= port_ovr_pkg::RST_PORT_A_PULLUP_ENABLE;
      end
      else if (wrCommit && regIdx == port_ovr_pkg::IDX_PORT_A_PULLUP_ENABLE)
      begin
         portAPullup_reg <= wrByte;
      end
   end

   // port control; reserved bit never stored
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         portControl_reg <= port_ovr_pkg::RST_PORT_CONTROL;
      end
      else if (wrCommit && regIdx == port_ovr_pkg::IDX_PORT_CONTROL)
      begin
         portControl_reg <= wrByte & port_ovr_pkg::PORT_CONTROL_MASK; // R14
      end
   end

   // two-flop synchronisers for all pad levels
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         padASync1_reg <= 8'h00;
         padASync2_reg <= 8'h00;
         padCSync1_reg <= 6'h00;
         padCSync2_reg <= 6'h00;
      end
      else
      begin
         padASync1_reg <= padAIn;
         padASync2_reg <= padASync1_reg; // R18
         padCSync1_reg <= padCIn;
         padCSync2_reg <= padCSync1_reg;
      end
   end

   // gap switching for the first and third ports
   bbm_gap #(.WIDTH(port_ovr_pkg::PORT_A_WIDTH)) u_gapA (
      .mclk(mclk),
      .rst_n(rst_n),
      .gapOn(portControl_reg[port_ovr_pkg::BIT_GAP_SWITCH_PORT_A]), // R15
      .dirIn(portADir_reg),
      .dirOut(padADirGap)
   );

   bbm_gap #(.WIDTH(port_ovr_pkg::PORT_C_WIDTH)) u_gapC (
      .mclk(mclk),
      .rst_n(rst_n),
      .gapOn(portControl_reg[port_ovr_pkg::BIT_GAP_SWITCH_PORT_C]), // R15
      .dirIn(portCDirReg),
      .dirOut(padCDirGap)
   );

   assign gapSwitchPortB = portControl_reg[port_ovr_pkg::BIT_GAP_SWITCH_PORT_B]; // R15

   // first port: register path only, bit i drives pad i
   genvar a;
   generate
      for (a = 0; a < port_ovr_pkg::PORT_A_WIDTH; a++)
      begin : g_padA
         pad_override_mux u_mux (
            .regPullup(portAPullup_reg[a]), // R18
            .regDir(padADirGap[a]),
            .regOut(portAOut_reg[a]),
            .pullupOvrEn(1'b0),
            .pullupOvrVal(1'b0),
            .dirOvrEn(1'b0),
            .dirOvrVal(1'b0),
            .outvalOvrEn(1'b0),
            .outvalOvrVal(1'b0),
            .inbufOvrEn(1'b0),
            .inbufOvrVal(1'b0),
            .padPullup(padAPullup[a]),
            .padDir(),
            .padOut(padAOut[a]),
            .inbufOn(inbufA[a])
         );
         assign padADriveN[a] = ~padADirGap[a];
      end
   endgenerate

   assign padALevel = padASync2_reg & inbufA;

   // third-port override terms
   assign spiHost = serialPeriphOn & serialPeriphHostMode;

   // select pad
   assign cPuoe[0] = 1'b0;
   assign cPuov[0] = 1'b0;
   assign cDdoe[0] = spiHost; // R11
   assign cDdov[0] = 1'b0; // R11
   assign cPvoe[0] = cmpAOutputDriveOn; // R11
   assign cPvov[0] = cmpAWaveform; // R11
   assign cDieoe[0] = pinchgSrc12 & pinchgGroup2On;
   assign cDieov[0] = pinchgSrc12 & pinchgGroup2On;

   // serial-clock pad
   assign cPuoe[1] = 1'b0;
   assign cPuov[1] = 1'b0;
   assign cDdoe[1] = twoWireOn | spiHost; // R9
   assign cDdov[1] = twoWireOn | twoWireClockDrive; // R9
   assign cPvoe[1] = twoWireOn | spiHost; // R9
   assign cPvov[1] = twoWireOn
      & (spiHost & spiHostClockDrive & (serialPeriphOn | serialPeriphHostMode)); // R9
   assign cDieoe[1] = pinchgSrc13 & pinchgGroup2On; // R10
   assign cDieov[1] = pinchgSrc13 & pinchgGroup2On; // R10

   // clock-output pad
   assign cPuoe[2] = clockOutFuse; // R6
   assign cPuov[2] = 1'b0; // R6
   assign cDdoe[2] = clockOutFuse | spiHost; // R7
   assign cDdov[2] = clockOutFuse; // R6
   assign cPvoe[2] = clockOutFuse | spiHost; // R7
   assign cPvov[2] = (clockOutFuse & mclk) | (clockOutFuse & spiHost & spiTargetTransmit); // R7
   assign cDieoe[2] = (pinchgSrc14 & pinchgGroup2On) | extIrq0Used; // R8
   assign cDieov[2] = (pinchgSrc14 & pinchgGroup2On) | extIrq0Used; // R8

   // reset pad
   assign cPuoe[3] = resetPinFunctionFlag; // R5
   assign cPuov[3] = 1'b1; // R5
   assign cDdoe[3] = resetPinFunctionFlag; // R5
   assign cDdov[3] = 1'b0; // R5
   assign cPvoe[3] = resetPinFunctionFlag; // R5
   assign cPvov[3] = 1'b0; // R5
   assign cDieoe[3] = resetPinFunctionFlag | (pinchgSrc15 & pinchgGroup2On); // R5
   assign cDieov[3] = resetPinFunctionFlag & pinchgSrc15 & pinchgGroup2On;

   // shared data pad
   assign cPuoe[4] = 1'b0;
   assign cPuov[4] = 1'b0;
   assign cDdoe[4] = spiHost | twoWireOn; // R3
   assign cDdov[4] = twoWireOn & twoWireDataDrive; // R3
   assign cPvoe[4] = twoWireOn | spiHost; // R3
   assign cPvov[4] = (twoWireOn & spiHost & spiHostTransmit)
      | (twoWireOn & (serialPeriphOn | serialPeriphHostMode)); // R3
   assign cDieoe[4] = pinchgSrc16 & pinchgGroup2On; // R4
   assign cDieov[4] = pinchgSrc16 & pinchgGroup2On; // R4

   // clock-input pad
   assign cPuoe[5] = externalSysclkSel; // R1
   assign cPuov[5] = 1'b0; // R1
   assign cDdoe[5] = externalSysclkSel; // R1
   assign cDdov[5] = 1'b0; // R1
   assign cPvoe[5] = externalSysclkSel; // R1
   assign cPvov[5] = 1'b0; // R1
   assign cDieoe[5] = externalSysclkSel | (pinchgSrc17 & pinchgGroup2On); // R2
   assign cDieov[5] = (externalSysclkSel & deepSleepActive)
      | (externalSysclkSel & pinchgSrc17 & pinchgGroup2On); // R2

   // third port: one override mux per pad
   genvar c;
   generate
      for (c = 0; c < port_ovr_pkg::PORT_C_WIDTH; c++)
      begin : g_padC
         pad_override_mux u_mux (
            .regPullup(portCPullupReg[c]),
            .regDir(padCDirGap[c]),
            .regOut(portCOutReg[c]),
            .pullupOvrEn(cPuoe[c]),
            .pullupOvrVal(cPuov[c]),
            .dirOvrEn(cDdoe[c]),
            .dirOvrVal(cDdov[c]),
            .outvalOvrEn(cPvoe[c]),
            .outvalOvrVal(cPvov[c]),
            .inbufOvrEn(cDieoe[c]),
            .inbufOvrVal(cDieov[c]),
            .padPullup(padCPullup[c]),
            .padDir(padCDir[c]),
            .padOut(padCOut[c]),
            .inbufOn(padCInbufOn[c])
         );
         assign padCDriveN[c] = ~padCDir[c];
      end
   endgenerate

   assign padCLevel = padCSync2_reg & padCInbufOn;

   // second-port buffer overrides from the analog input-off bits
   assign analogOff = portControl_reg[port_ovr_pkg::BIT_ANALOG11_INPUT_OFF:
      port_ovr_pkg::BIT_ANALOG8_INPUT_OFF];
   assign padBInbufOvrEn = pinchgSrcB & {4{pinchgGroup1On}} & analogOff; // R16
   assign padBInbufOvrVal = pinchgSrcB & {4{pinchgGroup1On}}; // R16

   // two-wire spike filter: a change must persist before it is passed on
   assign twRaw = {padCSync2_reg[port_ovr_pkg::PAD_SHARED_DATA],
      padCSync2_reg[port_ovr_pkg::PAD_SERIAL_CLOCK]};
   genvar f;
   generate
      for (f = 0; f < 2; f++)
      begin : g_filt
         always_ff @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               twFilt_reg[f] <= 1'b1;
               twCount_reg[f] <= 4'h0;
            end
            else if (!twoWireOn || twRaw[f] == twFilt_reg[f])
            begin
               twFilt_reg[f] <= twoWireOn ? twFilt_reg[f] : twRaw[f];
               twCount_reg[f] <= 4'h0;
            end
            else if (twCount_reg[f] == port_ovr_pkg::SPIKE_FILTER_CYCLES - 4'h1)
            begin
               twFilt_reg[f] <= twRaw[f]; // R12
               twCount_reg[f] <= 4'h0;
            end
            else
            begin
               twCount_reg[f] <= twCount_reg[f] + 4'h1;
            end
         end
      end
   endgenerate

   assign slewLimitData = twoWireOn; // R12
   assign slewLimitClock = twoWireOn; // R12

   // routing of the third-port pad inputs to their users
   assign extClockPinIn = padCIn[port_ovr_pkg::PAD_CLOCK_IN] & padCInbufOn[5];
   assign pinchgIn17 = padCLevel[port_ovr_pkg::PAD_CLOCK_IN]; // R13
   assign pinchgIn16 = padCLevel[port_ovr_pkg::PAD_SHARED_DATA]; // R4
   assign spiTargetReceive = padCLevel[port_ovr_pkg::PAD_SHARED_DATA]; // R4
   assign pinchgIn15 = padCLevel[port_ovr_pkg::PAD_RESET];
   assign pinchgIn14 = padCLevel[port_ovr_pkg::PAD_CLOCK_OUT]; // R8
   assign spiHostReceive = padCLevel[port_ovr_pkg::PAD_CLOCK_OUT]; // R8
   assign extIrq0Source = padCLevel[port_ovr_pkg::PAD_CLOCK_OUT]; // R8
   assign pinchgIn13 = padCLevel[port_ovr_pkg::PAD_SERIAL_CLOCK]; // R10
   assign capture1Input = padCLevel[port_ovr_pkg::PAD_SERIAL_CLOCK]; // R10
   assign spiClockIn = padCLevel[port_ovr_pkg::PAD_SERIAL_CLOCK]; // R10
   assign timer1CountSource = padCLevel[port_ovr_pkg::PAD_SERIAL_CLOCK]; // R10
   assign twoWireClockIn = twFilt_reg[0]; // R10
   assign twoWireDataIn = twFilt_reg[1]; // R12
   assign pinchgIn12 = padCLevel[port_ovr_pkg::PAD_SELECT]; // R11
   assign spiSelectIn = padCLevel[port_ovr_pkg::PAD_SELECT]; // R11
endmodule

// ===== sim/port_ovr_chk.sv
`timescale 1ns/1ps
// watches third-port overrides, second-port buffer values and register reads
module port_ovr_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [5:0] padCOut,
   input wire logic [5:0] padCDriveN,
   input wire logic [5:0] padCPullup,
   input wire logic [3:0] pinchgSrcB,
   input wire logic [3:0] padBInbufOvrVal,
   input wire logic externalSysclkSel,
   input wire logic resetPinFunctionFlag,
   input wire logic clockOutFuse,
   input wire logic pinchgGroup1On,
   input wire logic serialPeriphOn,
   input wire logic serialPeriphHostMode,
   input wire logic twoWireOn,
   input wire logic cmpAOutputDriveOn,
   input wire logic cmpAWaveform
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // pad overrides tied to their causes, plus the port control read
   a_extclk_pad_free: assert property (
      externalSysclkSel |-> !padCPullup[5] && padCDriveN[5] && !padCOut[5])
      else $error("clock input pad not released");
   a_reset_pad_forced: assert property (
      resetPinFunctionFlag |-> padCPullup[3] && padCDriveN[3] && !padCOut[3])
      else $error("reset pad not forced to pulled-up input");
   a_clkout_pad_drives: assert property (
      clockOutFuse |-> !padCPullup[2] && !padCDriveN[2])
      else $error("clock output pad not driven");
   a_select_host_input: assert property (
      serialPeriphOn && serialPeriphHostMode |-> padCDriveN[0])
      else $error("select pad driven in host mode");
   a_cmp_a_value: assert property (
      cmpAOutputDriveOn |-> padCOut[0] == cmpAWaveform)
      else $error("select pad value not compare waveform");
   a_twi_clock_drive: assert property (
      twoWireOn |-> !padCDriveN[1])
      else $error("serial clock pad not driven with two-wire on");
   a_portb_buf_value: assert property (
      padBInbufOvrVal == (pinchgSrcB & {4{pinchgGroup1On}}))
      else $error("second port buffer value wrong");
   a_ctrl_read_zero: assert property (
      ack_o && !we_i && adr_i[5:2] == 4'h8 |-> dat_o[31:8] == 24'h000000 && !dat_o[3])
      else $error("port control read shows reserved bits");
endmodule

// ===== sim/pad_board_model.sv
`timescale 1ns/1ps
// pad levels on the board: own drive, else pull-up, else the outside device
module pad_board_model (
   input wire logic [7:0] padAOut,
   input wire logic [7:0] padADriveN,
   input wire logic [7:0] padAPullup,
   input wire logic [7:0] boardA,
   input wire logic [5:0] padCOut,
   input wire logic [5:0] padCDriveN,
   input wire logic [5:0] padCPullup,
   input wire logic [5:0] boardC,
   output logic [7:0] padAIn,
   output logic [5:0] padCIn
);
   // resolved levels fed back to the pad inputs
   assign padAIn = (~padADriveN & padAOut) | (padADriveN & (padAPullup | boardA));
   assign padCIn = (~padCDriveN & padCOut) | (padCDriveN & (padCPullup | boardC));
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, gapSwitchPortB;
   logic [5:0] adr_i = 6'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000, dat_o, rv, rw;
   logic [7:0] padAIn, padAOut, padADriveN, padAPullup, boardA = 8'h00, dirV, outV, puV;
   logic [5:0] padCIn, padCOut, padCDriveN, padCPullup, padCInbufOn, boardC = 6'h00;
   logic [5:0] portCPullupReg = 6'h00, portCDirReg = 6'h00, portCOutReg = 6'h00;
   logic [3:0] pinchgSrcB = 4'h0, padBInbufOvrEn;
   logic [22:0] cfg = 23'h000000;
   logic [7:0] expQ[$];
   integer seed = 32'h9871;
   integer error_cnt = 0;
   integer comparisons = 0;

   // system clock, 4 ns period
   always #2 mclk = ~mclk;

   port_override_and_port_a_regs port_override_and_port_a_regs_inst (
      .mclk, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .padAIn, .padAOut, .padADriveN, .padAPullup, .padCIn, .padCOut, .padCDriveN,
      .padCPullup, .padCInbufOn, .padCLevel(), .slewLimitData(), .slewLimitClock(),
      .portCPullupReg, .portCDirReg, .portCOutReg, .pinchgSrcB, .padBInbufOvrEn,
      .padBInbufOvrVal(), .gapSwitchPortB, .externalSysclkSel(cfg[0]),
      .deepSleepActive(cfg[1]), .resetPinFunctionFlag(cfg[2]), .clockOutFuse(cfg[3]),
      .pinchgGroup1On(cfg[4]), .pinchgGroup2On(cfg[5]), .pinchgSrc12(cfg[6]),
      .pinchgSrc13(cfg[7]), .pinchgSrc14(cfg[8]), .pinchgSrc15(cfg[9]),
      .pinchgSrc16(cfg[10]), .pinchgSrc17(cfg[11]), .serialPeriphOn(cfg[12]),
      .serialPeriphHostMode(cfg[13]), .twoWireOn(cfg[14]), .twoWireDataDrive(cfg[15]),
      .twoWireClockDrive(cfg[16]), .spiHostTransmit(cfg[17]), .spiTargetTransmit(cfg[18]),
      .spiHostClockDrive(cfg[19]), .extIrq0Used(cfg[20]), .cmpAOutputDriveOn(cfg[21]),
      .cmpAWaveform(cfg[22]), .extClockPinIn(), .pinchgIn12(), .pinchgIn13(),
      .pinchgIn14(), .pinchgIn15(), .pinchgIn16(), .pinchgIn17(), .spiTargetReceive(),
      .spiHostReceive(), .spiClockIn(), .spiSelectIn(), .extIrq0Source(),
      .capture1Input(), .timer1CountSource(), .twoWireClockIn(), .twoWireDataIn()
   );

   pad_board_model pad_board_model_inst (
      .padAOut, .padADriveN, .padAPullup, .boardA, .padCOut, .padCDriveN, .padCPullup,
      .boardC, .padAIn, .padCIn
   );

   // compares one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_of_test;
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one classic bus cycle; a read notes its expected byte
   task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
      int n;
      @(posedge mclk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, d};
      sel_i <= 4'h1;
      if (!w)
         expQ.push_back(d);
      for (n = 0; n < 20 && ack_o !== 1'b1; n++)
         @(posedge mclk);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n == 20)
      begin
         $display("CHECK FAILED t=%0t no bus answer", $time);
         error_cnt++;
         end_of_test();
      end
   endtask

   // takes the oldest noted value whenever a read is answered
   always @(posedge mclk)
      if (ack_o === 1'b1 && we_i === 1'b0)
         check(dat_o, {24'h000000, expQ.pop_front()});

   // reset values, registers, pads, gap switching and overrides
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++)
         wb(1'b0, i[3:0], 8'h00);
      wb(1'b1, 4'h5, 8'hff);
      wb(1'b0, 4'h5, 8'h00);
      wb(1'b1, 4'h8, 8'hff);
      wb(1'b0, 4'h8, 8'hf7);
      check(gapSwitchPortB, 1'b1);
      wb(1'b1, 4'h8, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         rv = $random(seed);
         {dirV, outV, puV} = rv[23:0];
         boardA <= rv[31:24];
         wb(1'b1, 4'h1, dirV);
         wb(1'b1, 4'h2, outV);
         wb(1'b1, 4'h3, puV);
         repeat (4) @(posedge mclk);
         check(padAOut, outV);
         check(padADriveN, {~dirV});
         check(padAPullup, puV & ~dirV);
         wb(1'b0, 4'h0, (dirV & outV) | (~dirV & (puV | boardA)));
         wb(1'b0, 4'h3, puV);
      end
      for (int g = 0; g < 2; g++)
      begin
         wb(1'b1, 4'h8, {7'h00, g[0]});
         wb(1'b1, 4'h1, 8'h00);
         wb(1'b1, 4'h1, 8'h01);
         #1;
         check(padADriveN[0], g[0]);
         @(posedge mclk);
         #1;
         check(padADriveN[0], 1'b0);
      end
      wb(1'b1, 4'h8, 8'hf0);
      for (int k = 0; k < 60; k++)
      begin
         rv = $random(seed);
         rw = $random(seed);
         cfg <= rv[22:0];
         {pinchgSrcB, portCPullupReg, portCDirReg, portCOutReg} <= rw[21:0];
         boardC <= rw[27:22];
         @(posedge mclk);
         #1;
         check(padBInbufOvrEn, pinchgSrcB & {4{cfg[4]}});
         if (cfg[14])
            check(padCDriveN[4], {~cfg[15]});
         if (cfg[12] && cfg[13] && !cfg[3])
            check({padCDriveN[2], padCOut[2]}, 2'b10);
         if (!cfg[14] && !(cfg[12] && cfg[13]))
            check({padCDriveN[4], padCOut[4]}, {~portCDirReg[4], portCOutReg[4]});
         if (cfg[0] && !cfg[1] && !(cfg[11] && cfg[5]))
            check(padCInbufOn[5], 1'b0);
         if (!cfg[2])
            check(padCPullup[3], {portCPullupReg[3] & ~portCDirReg[3]});
         @(posedge mclk);
      end
      end_of_test();
   end
endmodule

bind port_override_and_port_a_regs port_ovr_chk port_ovr_chk_inst (
   .mclk, .rst_n, .we_i, .adr_i, .dat_o, .ack_o, .padCOut, .padCDriveN, .padCPullup,
   .pinchgSrcB, .padBInbufOvrVal, .externalSysclkSel, .resetPinFunctionFlag, .clockOutFuse,
   .pinchgGroup1On, .serialPeriphOn, .serialPeriphHostMode, .twoWireOn, .cmpAOutputDriveOn,
   .cmpAWaveform
);
